// ==== rtl/pixel_skid_buffer.sv ====
// Two-entry valid/ready buffer in the recorded pixel path.
// Assumes both sides run on ref_clk; a stall downstream back-pressures upstream.
`timescale 1ns/1ps
`default_nettype none
module pixel_skid_buffer (
	input wire logic ref_clk, // System clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic [video_sel_pkg::PIX_W:0] in_data, // Pixel plus frame-start flag.
	input wire logic in_valid, // Upstream word valid.
	output logic in_ready, // Buffer has room.
	output logic [video_sel_pkg::PIX_W:0] out_data, // Oldest word held.
	output logic out_valid, // Buffer holds a word.
	input wire logic out_ready // Downstream accepts.
);
	typedef struct packed {
		logic [1:0][video_sel_pkg::PIX_W:0] mem;
		logic rd_ptr;
		logic wr_ptr;
		logic [1:0] count;
	} buf_s;

	buf_s st_q;
	buf_s st_d;
	logic push;
	logic pop;

	assign in_ready = (st_q.count != 2'd2);
	assign out_valid = (st_q.count != 2'd0);
	assign out_data = st_q.mem[st_q.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wr_ptr] = in_data;
			st_d.wr_ptr = ~st_q.wr_ptr;
		end
		if (pop) begin
			st_d.rd_ptr = ~st_q.rd_ptr;
		end
		st_d.count = st_q.count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule // pixel_skid_buffer
`default_nettype wire

// ==== rtl/radar_video_channel_selector.sv ====
// Radar video channel selector: picks the recorded radar input and gates one image per period.
// Assumes sync inputs and contacts are asynchronous pins; the scanner status flag comes from
// the serial sentence decoder on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module radar_video_channel_selector #(
	parameter longint unsigned CAPTURE_CYCLES = video_sel_pkg::CAPTURE_CYCLES, // Capture period.
	parameter int unsigned DEBOUNCE_CYCLES = video_sel_pkg::DEBOUNCE_CYCLES, // Contact settle.
	parameter int unsigned SYNC_LOSS_CYCLES = video_sel_pkg::SYNC_LOSS_CYCLES, // Sync timeout.
	parameter int unsigned STATUS_LOSS_CYCLES = video_sel_pkg::STATUS_LOSS_CYCLES // Status timeout.
) (
	input wire logic ref_clk, // System clock, 100 MHz.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic mode_contact_a, // Contact A, high when closed.
	input wire logic mode_contact_b, // Contact B, high when closed.
	input wire logic primary_hsync, // Primary input horizontal sync.
	input wire logic primary_vsync, // Primary input vertical sync.
	input wire logic [video_sel_pkg::PIX_W-1:0] primary_pixel, // Primary input pixel.
	input wire logic primary_pixel_valid, // Primary pixel strobe.
	input wire logic secondary_hsync, // Secondary input horizontal sync.
	input wire logic secondary_vsync, // Secondary input vertical sync.
	input wire logic [video_sel_pkg::PIX_W-1:0] secondary_pixel, // Secondary input pixel.
	input wire logic secondary_pixel_valid, // Secondary pixel strobe.
	input wire logic status_update, // Pulse: a scanner status sentence was decoded.
	input wire logic status_scanner_running, // Scanner state carried by that sentence.
	output logic [video_sel_pkg::PIX_W-1:0] rec_pixel, // Recorded pixel.
	output logic rec_frame_start, // Pixel is the first of the image.
	output logic rec_valid, // Recorded word valid.
	input wire logic rec_ready, // Recorder accepts the word.
	output logic [1:0] active_mode, // Decoded mode.
	output logic [1:0] active_source, // Source now selected.
	output logic capture_busy // An image is being captured.
);
	localparam int unsigned DW = 32;
	localparam int unsigned CW = 48;

	typedef struct packed {
		logic [1:0] ca_sync;
		logic [1:0] cb_sync;
		logic [1:0] ph_sync;
		logic [1:0] pv_sync;
		logic [1:0] sh_sync;
		logic [1:0] sv_sync;
		logic ph_last;
		logic pv_last;
		logic sh_last;
		logic sv_last;
		logic [1:0] contact_last;
		logic [1:0] contact_stable;
		logic [DW-1:0] deb_cnt;
		video_sel_pkg::mode_e mode;
		logic [DW-1:0] p_h_age;
		logic [DW-1:0] p_v_age;
		logic [DW-1:0] s_h_age;
		logic [DW-1:0] s_v_age;
		logic status_seen;
		logic scanner_running;
		logic [DW-1:0] status_age;
		logic [CW-1:0] period_cnt;
		video_sel_pkg::cap_e cap;
		video_sel_pkg::src_e cap_src;
		logic first_pix;
		video_sel_pkg::src_e src;
		logic busy;
	} sel_s;

	sel_s st_q;
	sel_s st_d;
	video_sel_pkg::src_e sel_src;
	logic p_live;
	logic s_live;
	logic p_vs_edge;
	logic s_vs_edge;
	logic buf_in_valid;
	logic buf_in_ready;
	logic [video_sel_pkg::PIX_W:0] buf_in_data;
	logic [video_sel_pkg::PIX_W:0] buf_out_data;

	// Saturating age counter, used for every activity timeout.
	function automatic logic [DW-1:0] age_step(input logic [DW-1:0] age, input logic seen);
		if (seen) begin
			age_step = '0;
		end else if (age != '1) begin
			age_step = age + 32'd1;
		end else begin
			age_step = age;
		end
	endfunction

	// Frame start of whichever source is being captured; it opens and closes an image.
	function automatic logic frame_edge(input video_sel_pkg::src_e src, input logic p_edge,
		input logic s_edge);
		frame_edge = (src == video_sel_pkg::SRC_PRIMARY && p_edge)
			|| (src == video_sel_pkg::SRC_SECONDARY && s_edge);
	endfunction

	// ----------------------------------------------------------------
	// Source choice
	// ----------------------------------------------------------------
	assign p_live = (st_q.p_h_age < DW'(SYNC_LOSS_CYCLES)) && (st_q.p_v_age < DW'(SYNC_LOSS_CYCLES));
	assign s_live = (st_q.s_h_age < DW'(SYNC_LOSS_CYCLES)) && (st_q.s_v_age < DW'(SYNC_LOSS_CYCLES));
	assign p_vs_edge = st_q.pv_sync[1] && !st_q.pv_last;
	assign s_vs_edge = st_q.sv_sync[1] && !st_q.sv_last;

	always_comb begin
		sel_src = video_sel_pkg::SRC_NONE;
		case (st_q.mode)
			video_sel_pkg::MODE_PRIMARY: begin
				sel_src = p_live ? video_sel_pkg::SRC_PRIMARY : video_sel_pkg::SRC_NONE;
			end
			video_sel_pkg::MODE_SECONDARY: begin
				sel_src = s_live ? video_sel_pkg::SRC_SECONDARY : video_sel_pkg::SRC_NONE;
			end
			video_sel_pkg::MODE_AUTO: begin
				// Status sentences only steer radars that send them; others fall back to sync.
				if (st_q.status_seen) begin
					if (st_q.scanner_running) begin
						sel_src = p_live ? video_sel_pkg::SRC_PRIMARY : video_sel_pkg::SRC_NONE;
					end else begin
						sel_src = s_live ? video_sel_pkg::SRC_SECONDARY : video_sel_pkg::SRC_NONE;
					end
				end else if (p_live) begin
					sel_src = video_sel_pkg::SRC_PRIMARY;
				end else if (s_live) begin
					sel_src = video_sel_pkg::SRC_SECONDARY;
				end
			end
			default: begin
				sel_src = video_sel_pkg::SRC_NONE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// Two-flop synchronisers on the contact and sync pins.
		st_d.ca_sync = {st_q.ca_sync[0], mode_contact_a};
		st_d.cb_sync = {st_q.cb_sync[0], mode_contact_b};
		st_d.ph_sync = {st_q.ph_sync[0], primary_hsync};
		st_d.pv_sync = {st_q.pv_sync[0], primary_vsync};
		st_d.sh_sync = {st_q.sh_sync[0], secondary_hsync};
		st_d.sv_sync = {st_q.sv_sync[0], secondary_vsync};
		st_d.ph_last = st_q.ph_sync[1];
		st_d.pv_last = st_q.pv_sync[1];
		st_d.sh_last = st_q.sh_sync[1];
		st_d.sv_last = st_q.sv_sync[1];

		// ----------------------------------------------------------------
		// Contact debounce
		// ----------------------------------------------------------------
		// Contacts must hold one value for the full settle time before the mode moves.
		// Any change restarts the count, so a bouncing contact never latches a passing code.
		st_d.contact_last = {st_q.cb_sync[1], st_q.ca_sync[1]};
		if ({st_q.cb_sync[1], st_q.ca_sync[1]} == st_q.contact_stable) begin
			st_d.deb_cnt = '0;
		end else if ({st_q.cb_sync[1], st_q.ca_sync[1]} != st_q.contact_last) begin
			st_d.deb_cnt = '0;
		end else if (st_q.deb_cnt >= DW'(DEBOUNCE_CYCLES - 1)) begin
			st_d.deb_cnt = '0;
			st_d.contact_stable = {st_q.cb_sync[1], st_q.ca_sync[1]};
		end else begin
			st_d.deb_cnt = st_q.deb_cnt + 32'd1;
		end
		// Both open, also the unconnected switch, decodes as automatic; both closed is treated alike.
		case (st_q.contact_stable)
			2'b01: begin
				st_d.mode = video_sel_pkg::MODE_PRIMARY;
			end
			2'b10: begin
				st_d.mode = video_sel_pkg::MODE_SECONDARY;
			end
			default: begin
				st_d.mode = video_sel_pkg::MODE_AUTO;
			end
		endcase

		// Any edge of a sync line counts as presence.
		st_d.p_h_age = age_step(st_q.p_h_age, st_q.ph_sync[1] != st_q.ph_last);
		st_d.p_v_age = age_step(st_q.p_v_age, st_q.pv_sync[1] != st_q.pv_last);
		st_d.s_h_age = age_step(st_q.s_h_age, st_q.sh_sync[1] != st_q.sh_last);
		st_d.s_v_age = age_step(st_q.s_v_age, st_q.sv_sync[1] != st_q.sv_last);

		// Scanner status: a sentence marks the radar as reporting until sentences stop.
		st_d.status_age = age_step(st_q.status_age, status_update);
		if (status_update) begin
			st_d.status_seen = 1'b1;
			st_d.scanner_running = status_scanner_running;
		end else if (st_q.status_age >= DW'(STATUS_LOSS_CYCLES)) begin
			st_d.status_seen = 1'b0;
		end

		// ----------------------------------------------------------------
		// Capture sequencer
		// ----------------------------------------------------------------
		// Capture period divider: one enable pulse every period.
		if (st_q.period_cnt >= CW'(CAPTURE_CYCLES - 1)) begin
			st_d.period_cnt = '0;
		end else begin
			st_d.period_cnt = st_q.period_cnt + 48'd1;
		end

		case (st_q.cap)
			video_sel_pkg::CAP_IDLE: begin
				if (st_q.period_cnt >= CW'(CAPTURE_CYCLES - 1) && sel_src != video_sel_pkg::SRC_NONE) begin
					st_d.cap = video_sel_pkg::CAP_WAIT_FRAME;
					st_d.cap_src = sel_src;
				end
			end
			video_sel_pkg::CAP_WAIT_FRAME: begin
				if (sel_src != st_q.cap_src) begin
					st_d.cap = video_sel_pkg::CAP_IDLE;
				end else if (frame_edge(st_q.cap_src, p_vs_edge, s_vs_edge)) begin
					st_d.cap = video_sel_pkg::CAP_STREAM;
					st_d.first_pix = 1'b1;
				end
			end
			video_sel_pkg::CAP_STREAM: begin
				if (buf_in_valid && buf_in_ready) begin
					st_d.first_pix = 1'b0;
				end
				// The image ends at the next frame start, or early if the selected source changes.
				if (sel_src != st_q.cap_src || frame_edge(st_q.cap_src, p_vs_edge, s_vs_edge)) begin
					st_d.cap = video_sel_pkg::CAP_IDLE;
				end
			end
			default: begin
				st_d.cap = video_sel_pkg::CAP_IDLE;
			end
		endcase

		// Status outputs leave from flip-flops; the shown source trails the choice by one cycle.
		st_d.src = sel_src;
		st_d.busy = (st_d.cap != video_sel_pkg::CAP_IDLE);
	end

	// ----------------------------------------------------------------
	// Pixel path
	// ----------------------------------------------------------------
	// Pixel strobes are assumed to be resampled to ref_clk upstream; a full buffer drops pixels
	// of the frame in progress, which is the trade for not stalling a live video source.
	always_comb begin
		buf_in_valid = 1'b0;
		buf_in_data = '0;
		if (st_q.cap == video_sel_pkg::CAP_STREAM) begin
			if (st_q.cap_src == video_sel_pkg::SRC_PRIMARY) begin
				buf_in_valid = primary_pixel_valid;
				buf_in_data = {st_q.first_pix, primary_pixel};
			end else if (st_q.cap_src == video_sel_pkg::SRC_SECONDARY) begin
				buf_in_valid = secondary_pixel_valid;
				buf_in_data = {st_q.first_pix, secondary_pixel};
			end
		end
	end

	pixel_skid_buffer u_buf (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_data(buf_in_data),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.out_data(buf_out_data),
		.out_valid(rec_valid),
		.out_ready(rec_ready)
	);

	assign rec_pixel = buf_out_data[video_sel_pkg::PIX_W-1:0];
	assign rec_frame_start = buf_out_data[video_sel_pkg::PIX_W];
	assign active_mode = st_q.mode;
	assign active_source = st_q.src;
	assign capture_busy = st_q.busy;

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
			st_q.p_h_age <= '1;
			st_q.p_v_age <= '1;
			st_q.s_h_age <= '1;
			st_q.s_v_age <= '1;
			st_q.status_age <= '1;
		end else begin
			st_q <= st_d;
		end
	end
endmodule // radar_video_channel_selector
`default_nettype wire

// ==== rtl/video_sel_pkg.sv ====
// Constants and types for the radar video channel selector.
// Assumes a 100 MHz ref_clk and a synchronous active-high reset.
`default_nettype none
package video_sel_pkg;

	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned DEBOUNCE_US = 10_000;
	localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned SYNC_LOSS_US = 100_000;
	localparam int unsigned SYNC_LOSS_CYCLES = SYNC_LOSS_US * (CLK_HZ / 1_000_000);
	localparam int unsigned STATUS_LOSS_US = 10_000_000;
	localparam int unsigned STATUS_LOSS_CYCLES = STATUS_LOSS_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CAPTURE_S = 15;
	localparam longint unsigned CAPTURE_CYCLES = longint'(CAPTURE_S) * longint'(CLK_HZ);
	localparam int unsigned PIX_W = 24;
	localparam int unsigned BUF_DEPTH = 2;

	typedef enum logic [1:0] {
		MODE_AUTO = 2'b00,
		MODE_PRIMARY = 2'b01,
		MODE_SECONDARY = 2'b10
	} mode_e;

	typedef enum logic [1:0] {
		SRC_NONE = 2'b00,
		SRC_PRIMARY = 2'b01,
		SRC_SECONDARY = 2'b10
	} src_e;

	typedef enum logic [1:0] {
		CAP_IDLE = 2'b00,
		CAP_WAIT_FRAME = 2'b01,
		CAP_STREAM = 2'b10
	} cap_e;

endpackage
`default_nettype wire

// ==== tb/radar_display_pair.sv ====
// Partner model: two radar displays with sync, pixels and status sentences.
// Assumes everything runs on ref_clk; outputs follow one counter updated at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module radar_display_pair (
	input wire logic ref_clk, // System clock.
	input wire logic p_on, // Primary display powered.
	input wire logic s_on, // Secondary display powered.
	input wire logic st_on, // Primary radar sends status sentences.
	input wire logic st_run, // Reported scanner state.
	output logic primary_hsync, // Primary line sync.
	output logic primary_vsync, // Primary frame sync.
	output logic [video_sel_pkg::PIX_W-1:0] primary_pixel, // Primary pixel.
	output logic primary_pixel_valid, // Primary strobe.
	output logic secondary_hsync, // Secondary line sync.
	output logic secondary_vsync, // Secondary frame sync.
	output logic [video_sel_pkg::PIX_W-1:0] secondary_pixel, // Secondary pixel.
	output logic secondary_pixel_valid, // Secondary strobe.
	output logic status_update, // Sentence pulse.
	output logic status_scanner_running // Scanner state.
);
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	// A frame lasts 200 cycles so that whole frames fit one capture period.
	// A display that is off stops its sync and puts a changing pattern on its data.
	int unsigned t_q = 0;
	logic fr;
	always_ff @(posedge ref_clk) begin
		t_q <= t_q + 1;
	end
	assign fr = (t_q % 200) < 8;
	assign primary_hsync = p_on & t_q[3];
	assign primary_vsync = p_on & fr;
	assign primary_pixel = p_on ? {8'h11, t_q[15:0]} : {8'h5a, ~t_q[15:0]};
	assign primary_pixel_valid = p_on & (t_q[1:0] == 2'd0);
	assign secondary_hsync = s_on & t_q[3];
	assign secondary_vsync = s_on & fr;
	assign secondary_pixel = s_on ? {8'h22, t_q[15:0]} : {8'ha5, ~t_q[15:0]};
	assign secondary_pixel_valid = s_on & (t_q[1:0] == 2'd0);
	assign status_update = st_on & (t_q % 300 == 0);
	assign status_scanner_running = st_on ? st_run : t_q[0];
endmodule // radar_display_pair
`default_nettype wire

// ==== tb/selector_sva.sv ====
// Checker: concurrent assertions on the ports of the radar video channel selector.
// Assumes one clock domain, ref_clk, with the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module selector_sva #(
	parameter longint unsigned CAPTURE_CYCLES = 2000, // Capture period.
	parameter int unsigned DEBOUNCE_CYCLES = 4 // Contact settle.
) (
	input wire logic ref_clk, // System clock.
	input wire logic reset, // Synchronous reset.
	input wire logic mode_contact_a, // Contact A.
	input wire logic mode_contact_b, // Contact B.
	input wire logic [video_sel_pkg::PIX_W-1:0] rec_pixel, // Recorded pixel.
	input wire logic rec_frame_start, // First pixel flag.
	input wire logic rec_valid, // Recorded word valid.
	input wire logic rec_ready, // Recorder accepts.
	input wire logic [1:0] active_mode, // Decoded mode.
	input wire logic [1:0] active_source, // Selected source.
	input wire logic capture_busy // Capture running.
);
	localparam int MW = DEBOUNCE_CYCLES;
	longint unsigned gap_q;
	logic seen_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------------------------------
	// Capture spacing
	// ----------------------------------------------------------------
	// Captures may skip periods with no source, so only multiples are checked.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			gap_q <= 0;
			seen_q <= 1'b0;
		end else if ($rose(capture_busy)) begin
			gap_q <= 1;
			seen_q <= 1'b1;
		end else begin
			gap_q <= gap_q + 1;
		end
	end
	sequence held_a;
		(mode_contact_a && !mode_contact_b) [*8];
	endsequence
	sequence held_b;
		(mode_contact_b && !mode_contact_a) [*8];
	endsequence
	sequence held_auto;
		(mode_contact_a == mode_contact_b) [*8];
	endsequence
	chk_mode_primary: assert property (held_a |-> ##[1:MW] active_mode == 2'd1)
		else $error("contact A held without primary mode");
	chk_mode_secondary: assert property (held_b |-> ##[1:MW] active_mode == 2'd2)
		else $error("contact B held without secondary mode");
	chk_mode_auto: assert property (held_auto |-> ##[1:MW] active_mode == 2'd0)
		else $error("equal contacts without automatic mode");
	chk_codes_legal: assert property (active_mode != 2'd3 && active_source != 2'd3)
		else $error("illegal mode or source code");
	// The shown source is registered one cycle after the mode, so a fresh mode is judged a cycle later.
	chk_fixed_primary: assert property (active_mode == 2'd1 && $past(active_mode) == 2'd1
		|-> active_source != 2'd2)
		else $error("secondary chosen in primary mode");
	chk_fixed_secondary: assert property (active_mode == 2'd2 && $past(active_mode) == 2'd2
		|-> active_source != 2'd1)
		else $error("primary chosen in secondary mode");
	chk_capture_source: assert property ($rose(capture_busy) |-> active_source != 2'd0)
		else $error("capture started with no source");
	chk_capture_period: assert property ($rose(capture_busy) && seen_q |-> gap_q % CAPTURE_CYCLES == 0)
		else $error("capture start off the period");
	chk_stall_hold: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_pixel)
		&& $stable(rec_frame_start))
		else $error("recorded word lost under stall");
endmodule // selector_sva
bind radar_video_channel_selector selector_sva #(.CAPTURE_CYCLES(CAPTURE_CYCLES),
	.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) selector_sva_i (.ref_clk, .reset, .mode_contact_a,
	.mode_contact_b, .rec_pixel, .rec_frame_start, .rec_valid, .rec_ready, .active_mode,
	.active_source, .capture_busy);
`default_nettype wire

// ==== tb/testbench.sv ====
// Testbench: drives contacts and recorder stalls, compares with an integer model.
// Assumes the partner model supplies both radar inputs and the status sentences.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ----------------------------------------------------------------
	// Signals and model state
	// ----------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic mode_contact_a = 1'b0;
	logic mode_contact_b = 1'b0;
	logic rec_ready = 1'b1;
	logic p_on = 1'b0, s_on = 1'b0, st_on = 1'b0, st_run = 1'b0;
	logic primary_hsync, primary_vsync, primary_pixel_valid, secondary_hsync, secondary_vsync;
	logic secondary_pixel_valid, status_update, status_scanner_running, rec_frame_start, rec_valid;
	logic capture_busy;
	logic [video_sel_pkg::PIX_W-1:0] primary_pixel, secondary_pixel, rec_pixel;
	logic [1:0] active_mode, active_source;
	logic [31:0] rnd = 32'h588b_a0d3;
	int err_total = 0;
	int checks_done = 0;
	int exp_s = 0;
	int cycles = 0;
	bit steady = 1'b0;
	int frames[$];
	radar_video_channel_selector #(.CAPTURE_CYCLES(2000), .DEBOUNCE_CYCLES(4), .SYNC_LOSS_CYCLES(200),
		.STATUS_LOSS_CYCLES(1000)) radar_video_channel_selector_i (.ref_clk, .reset, .mode_contact_a,
		.mode_contact_b, .primary_hsync, .primary_vsync, .primary_pixel, .primary_pixel_valid,
		.secondary_hsync, .secondary_vsync, .secondary_pixel, .secondary_pixel_valid, .status_update,
		.status_scanner_running, .rec_pixel, .rec_frame_start, .rec_valid, .rec_ready, .active_mode,
		.active_source, .capture_busy);
	radar_display_pair radar_display_pair_i (.ref_clk, .p_on, .s_on, .st_on, .st_run, .primary_hsync,
		.primary_vsync, .primary_pixel, .primary_pixel_valid, .secondary_hsync, .secondary_vsync,
		.secondary_pixel, .secondary_pixel_valid, .status_update, .status_scanner_running);
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	task automatic results();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// Random stalls of the recorder; every accepted word must come from the expected radar.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		rnd <= xs(rnd);
		rec_ready <= rnd[1:0] != 2'd0;
		if (steady && rec_valid === 1'b1 && rec_ready === 1'b1) begin
			checks_done++;
			if (exp_s == 0 || rec_pixel[23:16] !== 8'(exp_s * 17)) begin
				err_total++;
				$display("Error at %0t: word from wrong channel", $time);
			end
			if (rec_frame_start === 1'b1) frames.push_back(cycles);
		end
		if (cycles == 60000) begin
			err_total++;
			$display("Error at %0t: run did not finish", $time);
			results();
		end
	end
	// Contacts bounce briefly before settling; the bounce is shorter than the settle time.
	task automatic run_case(input logic b, input logic a, input logic p, input logic s, input logic so,
		input logic sr);
		int em;
		int es;
		#1 steady = 1'b0;
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			{mode_contact_b, mode_contact_a} <= rnd[5:4];
		end
		@(posedge ref_clk);
		{mode_contact_b, mode_contact_a, p_on, s_on, st_on, st_run} <= {b, a, p, s, so, sr};
		em = (a && !b) ? 1 : ((b && !a) ? 2 : 0);
		es = so ? (sr ? (p ? 1 : 0) : (s ? 2 : 0)) : (p ? 1 : (s ? 2 : 0));
		if (em == 1) es = p ? 1 : 0;
		if (em == 2) es = s ? 2 : 0;
		repeat (1300) @(posedge ref_clk);
		#1 exp_s = es;
		steady = 1'b1;
		frames.delete();
		repeat (4000) @(posedge ref_clk);
		#1 checks_done += 3;
		if (active_mode !== 2'(em) || active_source !== 2'(es)
			|| frames.size() != (es != 0 ? 2 : 0)) begin
			err_total++;
			$display("Error at %0t: mode %0d source %0d frames %0d", $time, active_mode, active_source,
				frames.size());
		end
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		run_case(0, 0, 1, 1, 0, 0);
		run_case(0, 0, 0, 1, 0, 0);
		run_case(0, 1, 0, 1, 0, 0);
		run_case(1, 0, 1, 1, 0, 0);
		run_case(1, 0, 1, 0, 0, 0);
		run_case(1, 1, 1, 1, 0, 0);
		run_case(0, 0, 0, 1, 1, 1);
		run_case(0, 0, 1, 1, 1, 0);
		run_case(0, 0, 1, 1, 0, 0);
		results();
	end
endmodule // testbench
`default_nettype wire
